// ===== src/asq_pkg.sv
package asq_pkg;

  // register byte offsets
  localparam logic [11:0] OFF_CTRL  = 12'h004;
  localparam logic [11:0] OFF_QUEUE = 12'h008;
  localparam logic [11:0] OFF_IRQC  = 12'h00C;
  localparam logic [11:0] OFF_STAT  = 12'h010;
  localparam logic [11:0] OFF_CLR   = 12'h014;

  // queue geometry
  localparam int          DEPTH     = 4;
  localparam int          PTR_W     = 2;
  localparam int          CNT_W     = 3;
  localparam int          VAL_W     = 10;
  localparam int          PIN_W     = 3;
  localparam logic [2:0]  CNT_FULL  = 3'h4;
  localparam logic [2:0]  CNT_EMPTY = 3'h0;

  // queue read layout
  localparam int          Q_VAL_LSB = 0;
  localparam int          Q_PIN_LSB = 10;

  // source pin codes
  localparam logic [2:0]  PIN_FIRST = 3'h1;
  localparam logic [2:0]  PIN_LAST  = 3'h4;

  // control register
  localparam int          CT_SRST   = 0;

  // interrupt control layout
  localparam int          IC_GIE    = 9;
  localparam int          IC_LVL    = 8;
  localparam int          IC_UNF    = 7;
  localparam int          IC_OVF    = 6;
  localparam int          IC_DMA    = 3;
  localparam int          IC_THR    = 0;
  localparam logic [2:0]  THR_MAX   = 3'h3;
  localparam logic [2:0]  THR_RESET = 3'h0;

  // status layout, sticky group sits at 8:6
  localparam int          ST_IRQ    = 9;
  localparam int          ST_LVL    = 8;
  localparam int          ST_UNF    = 7;
  localparam int          ST_OVF    = 6;
  localparam int          ST_EMPTY  = 5;
  localparam int          ST_FULL   = 4;
  localparam int          ST_CNT    = 0;
  localparam logic [2:0]  STICKY_0  = 3'h0;

  typedef struct packed {
    logic             valid;
    logic [PIN_W-1:0] pin;
    logic [VAL_W-1:0] value;
  } asq_sample_s;

  typedef struct packed {
    logic [PIN_W-1:0] pin;
    logic [VAL_W-1:0] value;
  } asq_entry_s;

  typedef enum logic [1:0] {
    AP_IDLE  = 2'b00,
    AP_SETUP = 2'b01,
    AP_DONE  = 2'b10
  } asq_apb_e;

endpackage

// ===== src/asq_sample_queue.sv
`timescale 1ns/1ps
// Function
// (RULE_01) queue holds at most four samples
// (RULE_02) queue read gives oldest value in 9:0, pin code 12:10, zeros above
// (RULE_03) pin codes 1..4 name inputs one to four, others name none
// (RULE_04) reading an empty queue sets underflow; value is undefined
// (RULE_05) pin code on an underflow read is undefined
// (RULE_06) global enable bit 9 gates every interrupt
// (RULE_07) per-source enables: level bit 8, underflow bit 7, overflow bit 6
// (RULE_08) dma enable bit 3 requests service when fill exceeds threshold; code requests once fill reaches it, as for level
// (RULE_09) threshold 0..3 means one..four entries; 4..7 invalid
// (RULE_10) level status bit 8 set at or above threshold, cleared by writing 1
// (RULE_11) underflow bit 7 sticky until 1 written; 0 has no effect
// (RULE_12) overflow bit 6 set on sample into full queue, sticky until cleared
// (RULE_13) empty flag bit 5 high when no entries, 1 out of reset
// (RULE_14) full flag bit 4 high exactly when four entries held
// (RULE_15) count field 2:0 gives entries, 0 to 4, never above
// (RULE_16) status bit 9 mirrors the interrupt output
// (RULE_17) soft reset bit empties queue and clears status while set
// (RULE_18) each queue read pops oldest entry; empty read keeps count zero
// (RULE_19) irq = gie and any sticky bit with its enable; full queue drops samples
module asq_sample_queue (
  input  wire logic                 pclk,
  input  wire logic                 presetn,
  input  wire logic                 psel,
  input  wire logic                 penable,
  input  wire logic                 pwrite,
  input  wire logic [11:0]          paddr,
  input  wire logic [31:0]          pwdata,
  output logic      [31:0]          prdata,
  output logic                      pready,
  output logic                      pslverr,
  input  wire asq_pkg::asq_sample_s sample_in,
  output logic                      dma_req,
  output logic                      irq
);

  ////////////////////////////////////////////////////////////////////////////
  // helpers

  // threshold code v means v+1 entries; invalid codes never match
  function automatic logic level_met(input logic [2:0] cnt, input logic [2:0] thr);
    level_met = (thr <= asq_pkg::THR_MAX) && (cnt > thr); // RULE_09
  endfunction

  function automatic logic [2:0] sticky_bits(input logic [31:0] d);
    sticky_bits = d[asq_pkg::ST_LVL:asq_pkg::ST_OVF];
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // state

  asq_pkg::asq_entry_s mem_r [asq_pkg::DEPTH];
  logic [asq_pkg::PTR_W-1:0] wr_ptr_r;
  logic [asq_pkg::PTR_W-1:0] rd_ptr_r;
  logic [asq_pkg::CNT_W-1:0] count_r;
  logic [asq_pkg::CNT_W-1:0] count_nxt;
  logic                      srst_r;
  logic                      gie_r;
  logic [2:0]                ien_r;
  logic                      dma_en_r;
  logic [2:0]                thr_r;
  logic [2:0]                sts_r;
  logic [2:0]                sts_nxt;
  logic                      irq_r;
  logic                      dma_r;
  logic [31:0]               prdata_r;
  logic                      pready_r;
  logic                      pslverr_r;
  logic                      rd_empty_r;
  asq_pkg::asq_apb_e         ap_st_r;
  asq_pkg::asq_apb_e         ap_st_nxt;

  ////////////////////////////////////////////////////////////////////////////
  // apb decode

  wire sel_ctrl  = (paddr == asq_pkg::OFF_CTRL);
  wire sel_queue = (paddr == asq_pkg::OFF_QUEUE);
  wire sel_irqc  = (paddr == asq_pkg::OFF_IRQC);
  wire sel_stat  = (paddr == asq_pkg::OFF_STAT);
  wire sel_clr   = (paddr == asq_pkg::OFF_CLR);
  wire addr_hit  = sel_ctrl | sel_queue | sel_irqc | sel_stat | sel_clr;
  wire setup     = psel & ~penable;
  wire acc_done  = psel & penable & pready_r;
  wire wr_en     = acc_done & pwrite & ~pslverr_r;
  wire q_read    = acc_done & ~pwrite & sel_queue;

  ////////////////////////////////////////////////////////////////////////////
  // queue datapath

  wire empty   = (count_r == asq_pkg::CNT_EMPTY);                          // RULE_13
  wire full    = (count_r == asq_pkg::CNT_FULL);                           // RULE_14
  // emptiness is judged at setup, so a sample landing mid-access is not lost
  wire pop     = q_read & ~rd_empty_r & ~srst_r;                           // RULE_18
  wire unf_evt = q_read & rd_empty_r & ~srst_r;                            // RULE_04
  // a pop in the same cycle frees the slot the arriving sample needs
  wire push    = sample_in.valid & (~full | pop) & ~srst_r;                // RULE_01
  wire ovf_evt = sample_in.valid & full & ~pop & ~srst_r;                  // RULE_19
  wire lvl_evt = level_met(count_r, thr_r) & ~srst_r;                      // RULE_10

  asq_pkg::asq_entry_s head;
  assign head = mem_r[rd_ptr_r];

  always_comb
  begin
    count_nxt = count_r;
    case ({push, pop})
      2'b10:   count_nxt = count_r + 3'h1;
      2'b01:   count_nxt = count_r - 3'h1;                                 // RULE_15
      default: count_nxt = count_r;
    endcase
    if (srst_r)
    begin
      count_nxt = asq_pkg::CNT_EMPTY;                                      // RULE_17
    end
  end

  always_ff @(posedge pclk)
  begin
    if (push)
    begin
      mem_r[wr_ptr_r] <= '{pin: sample_in.pin, value: sample_in.value};    // RULE_03
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      wr_ptr_r <= '0;
      rd_ptr_r <= '0;
      count_r  <= asq_pkg::CNT_EMPTY;
    end
    else if (srst_r)
    begin
      wr_ptr_r <= '0;
      rd_ptr_r <= '0;
      count_r  <= asq_pkg::CNT_EMPTY;                                      // RULE_17
    end
    else
    begin
      wr_ptr_r <= wr_ptr_r + 2'(push);
      rd_ptr_r <= rd_ptr_r + 2'(pop);                                      // RULE_18
      count_r  <= count_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // control and interrupt enable registers

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      srst_r   <= 1'b0;
      gie_r    <= 1'b0;
      ien_r    <= 3'h0;
      dma_en_r <= 1'b0;
      thr_r    <= asq_pkg::THR_RESET;
    end
    else if (wr_en)
    begin
      if (sel_ctrl)
      begin
        srst_r <= pwdata[asq_pkg::CT_SRST];                                // RULE_17
      end
      if (sel_irqc)
      begin
        gie_r    <= pwdata[asq_pkg::IC_GIE];                               // RULE_06
        ien_r    <= pwdata[asq_pkg::IC_LVL:asq_pkg::IC_OVF];               // RULE_07
        dma_en_r <= pwdata[asq_pkg::IC_DMA];                               // RULE_08
        thr_r    <= pwdata[asq_pkg::IC_THR+2:asq_pkg::IC_THR];             // RULE_09
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // sticky status, set wins over clear

  wire [2:0] clr_bits = (wr_en & (sel_stat | sel_clr)) ? sticky_bits(pwdata) : 3'h0;
  wire [2:0] set_bits = {lvl_evt, unf_evt, ovf_evt};

  always_comb
  begin
    sts_nxt = set_bits | (sts_r & ~clr_bits);                              // RULE_11
    if (srst_r)
    begin
      sts_nxt = asq_pkg::STICKY_0;                                         // RULE_17
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      sts_r <= asq_pkg::STICKY_0;
      irq_r <= 1'b0;
      dma_r <= 1'b0;
    end
    else
    begin
      sts_r <= sts_nxt;                                                    // RULE_12
      irq_r <= gie_r & |(sts_r & ien_r);                                   // RULE_19
      // dma follows the fill alone, not the interrupt enables
      dma_r <= dma_en_r & level_met(count_r, thr_r) & ~srst_r;             // RULE_08
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // read mux and apb answer, one wait-free access phase

  wire [31:0] rd_queue = {19'h0, head.pin, head.value};                    // RULE_02
  wire [31:0] rd_ctrl  = {31'h0, srst_r};
  wire [31:0] rd_irqc  = {22'h0, gie_r, ien_r, 2'h0, dma_en_r, thr_r};
  wire [31:0] rd_stat  = {22'h0, irq_r, sts_r, empty, full, 1'b0, count_r}; // RULE_16
  wire [31:0] rd_mux   = sel_queue ? rd_queue :
                         sel_ctrl  ? rd_ctrl  :
                         sel_irqc  ? rd_irqc  :
                         sel_stat  ? rd_stat  : 32'h0;

  always_comb
  begin
    ap_st_nxt = ap_st_r;
    case (ap_st_r)
      asq_pkg::AP_IDLE:  ap_st_nxt = setup ? asq_pkg::AP_SETUP : asq_pkg::AP_IDLE;
      asq_pkg::AP_SETUP: ap_st_nxt = acc_done ? asq_pkg::AP_DONE : asq_pkg::AP_SETUP;
      asq_pkg::AP_DONE:  ap_st_nxt = setup ? asq_pkg::AP_SETUP : asq_pkg::AP_IDLE;
      default:           ap_st_nxt = asq_pkg::AP_IDLE;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      ap_st_r    <= asq_pkg::AP_IDLE;
      prdata_r   <= 32'h0;
      pready_r   <= 1'b0;
      pslverr_r  <= 1'b0;
      rd_empty_r <= 1'b1;
    end
    else
    begin
      ap_st_r <= ap_st_nxt;
      if (setup)
      begin
        pready_r   <= 1'b1;
        pslverr_r  <= ~addr_hit;
        prdata_r   <= pwrite ? 32'h0 : rd_mux;                             // RULE_05
        rd_empty_r <= empty;
      end
      else if (acc_done)
      begin
        pready_r  <= 1'b0;
        pslverr_r <= 1'b0;
      end
    end
  end

  assign prdata  = prdata_r;
  assign pready  = pready_r;
  assign pslverr = pslverr_r;
  assign irq     = irq_r;
  assign dma_req = dma_r;

  ////////////////////////////////////////////////////////////////////////////
  // checks

  sequence s_q_setup;
    psel && !penable && !pwrite && sel_queue;
  endsequence

  sequence s_q_access;
    psel && penable && pready_r;
  endsequence

  AST_COUNT_BOUND: assert property ( // RULE_01
    @(posedge pclk) disable iff (!presetn)
    count_r <= asq_pkg::CNT_FULL)
    else $error("queue count above four");

  AST_COUNT_CODE: assert property ( // RULE_15
    @(posedge pclk) disable iff (!presetn)
    !pop && !push && !srst_r |=> count_r == $past(count_r))
    else $error("count moved without push or pop");

  AST_QUEUE_READ_LAYOUT: assert property ( // RULE_02
    @(posedge pclk) disable iff (!presetn)
    s_q_setup ##1 s_q_access |-> prdata_r[31:13] == 19'h0
      && prdata_r[9:0] == $past(head.value))
    else $error("queue read layout wrong");

  AST_PIN_CODE: assert property ( // RULE_03
    @(posedge pclk) disable iff (!presetn)
    s_q_setup ##1 s_q_access |-> $past(empty) || prdata_r[12:10] == $past(head.pin))
    else $error("queue read pin code lost");

  AST_UNDERFLOW_SET: assert property ( // RULE_04
    @(posedge pclk) disable iff (!presetn)
    (s_q_setup and (empty && !srst_r)) ##1 (s_q_access and !srst_r)
      |=> sts_r[1] && (count_r == $past(count_r) + 3'($past(push))))
    else $error("empty read did not flag underflow");

  AST_UNDERFLOW_HOLD: assert property ( // RULE_11
    @(posedge pclk) disable iff (!presetn)
    sts_r[1] && !srst_r && !(wr_en && (sel_stat || sel_clr) && pwdata[asq_pkg::ST_UNF])
      |=> sts_r[1])
    else $error("underflow flag dropped on its own");

  AST_OVERFLOW_SET: assert property ( // RULE_12
    @(posedge pclk) disable iff (!presetn)
    sample_in.valid && full && !pop && !srst_r
      |=> sts_r[0] && count_r == asq_pkg::CNT_FULL)
    else $error("sample into full queue not flagged");

  AST_GIE_GATE: assert property ( // RULE_06
    @(posedge pclk) disable iff (!presetn)
    !gie_r |=> !irq_r)
    else $error("interrupt with global enable clear");

  AST_IRQ_SOURCE: assert property ( // RULE_07
    @(posedge pclk) disable iff (!presetn)
    irq_r |-> $past(sts_r & ien_r) != 3'h0)
    else $error("interrupt without enabled source");

  AST_LEVEL_SET: assert property ( // RULE_10
    @(posedge pclk) disable iff (!presetn)
    !srst_r && count_r > thr_r && thr_r <= asq_pkg::THR_MAX |=> sts_r[2])
    else $error("level flag missed");

  AST_DMA_REQ: assert property ( // RULE_08
    @(posedge pclk) disable iff (!presetn)
    dma_req |-> $past(dma_en_r) && $past(count_r) > $past(thr_r))
    else $error("dma request without fill");

  AST_SRST_CLEAR: assert property ( // RULE_17
    @(posedge pclk) disable iff (!presetn)
    srst_r [*2] |-> count_r == asq_pkg::CNT_EMPTY && sts_r == asq_pkg::STICKY_0)
    else $error("soft reset did not clear queue");

  AST_STATUS_MIRROR: assert property ( // RULE_16
    @(posedge pclk) disable iff (!presetn)
    psel && !penable && !pwrite && sel_stat ##1 s_q_access
      |-> prdata_r[asq_pkg::ST_IRQ] == $past(irq_r))
    else $error("status irq bit differs from output");

  AST_POP_COUNT: assert property ( // RULE_18
    @(posedge pclk) disable iff (!presetn)
    pop && !push |=> count_r == $past(count_r) - 3'h1)
    else $error("pop did not decrement count");

  // ready must only ever stand in the access phase the state machine tracks
  AST_APB_READY: assert property (
    @(posedge pclk) disable iff (!presetn)
    pready_r |-> ap_st_r == asq_pkg::AP_SETUP)
    else $error("ready outside an access phase");

endmodule // asq_sample_queue

// ===== testbench/asq_conv_model.sv
`timescale 1ns/1ps
module asq_conv_model (
  input  wire logic            pclk,
  input  wire logic            presetn,
  input  wire logic            go,
  input  wire logic [2:0]      pin,
  input  wire logic [9:0]      value,
  output asq_pkg::asq_sample_s sample_out
);
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      sample_out <= '0;
    end
    else
    begin
      // one pulse per conversion; idle data toggles so stale data never passes
      sample_out.valid <= go;
      sample_out.pin   <= go ? pin : ~sample_out.pin;
      sample_out.value <= go ? value : ~sample_out.value;
    end
  end
endmodule // asq_conv_model

// ===== testbench/tb_top.sv
`timescale 1ns/1ps
module tb_top;
  logic                 pclk;
  logic                 presetn;
  logic                 psel;
  logic                 penable;
  logic                 pwrite;
  logic [11:0]          paddr;
  logic [31:0]          pwdata;
  logic [31:0]          prdata;
  logic                 pready;
  logic                 pslverr;
  asq_pkg::asq_sample_s smp;
  logic                 dma_req;
  logic                 irq;
  logic                 go;
  logic [2:0]           pin;
  logic [9:0]           value;
  logic [31:0]          rd;
  logic                 err;
  int                   n_fail;
  int                   checked;
  int                   t;
  int                   k;

  ////////////////////////////////////////////////////////////////////////
  asq_sample_queue DUT (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .sample_in(smp), .dma_req(dma_req), .irq(irq));
  asq_conv_model conv (.pclk(pclk), .presetn(presetn), .go(go), .pin(pin), .value(value),
    .sample_out(smp));

  always #5 pclk = ~pclk;

  ////////////////////////////////////////////////////////////////////////
  task automatic complete_run();
    $display("checks %0d mismatches %0d", checked, n_fail);
    if (n_fail == 0 && checked > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    checked++;
    if (got !== exp)
    begin
      n_fail++;
      $display("[ERR] %s expected %h seen %h", name, exp, got);
    end
  endtask

  // zero wait states expected, but the loop still bounds a hang
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int i;
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    i = 0;
    do
    begin
      @(posedge pclk);
      i++;
    end
    while (pready !== 1'b1 && i < 20);
    if (i >= 20)
    begin
      n_fail++;
      complete_run();
    end
    rd = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic rchk(input string name, input logic [11:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    chk(name, exp, rd);
  endtask

  task automatic send(input logic [2:0] p, input logic [9:0] v);
    @(posedge pclk);
    go    <= 1'b1;
    pin   <= p;
    value <= v;
    @(posedge pclk);
    go <= 1'b0;
    repeat (4) @(posedge pclk);
  endtask

  task automatic soft_clear();
    apb(1'b1, asq_pkg::OFF_CTRL, 32'h1);
    apb(1'b1, asq_pkg::OFF_CTRL, 32'h0);
  endtask

  ////////////////////////////////////////////////////////////////////////
  initial
  begin
    pclk = 1'b0; presetn = 1'b0; psel = 1'b0; penable = 1'b0; pwrite = 1'b0;
    paddr = 12'h0; pwdata = 32'h0; go = 1'b0; pin = 3'h0; value = 10'h0;
    n_fail = 0; checked = 0;
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    rchk("status reset", asq_pkg::OFF_STAT, 32'h0000_0020);
    chk("irq reset", 32'h0, {31'h0, irq});
    $display("test reset done");

    for (k = 0; k < 5; k++)
      send(3'(k % 4 + 1), 10'h3F0 + 10'(k));
    // fifth sample hits a full queue: dropped, overflow flagged
    rchk("status full", asq_pkg::OFF_STAT, 32'h0000_0154);
    apb(1'b1, asq_pkg::OFF_STAT, 32'h0);
    rchk("status w0", asq_pkg::OFF_STAT, 32'h0000_0154);
    apb(1'b1, asq_pkg::OFF_STAT, 32'h0000_01C0);
    // level re-sets at once since four entries still meet threshold
    rchk("status w1c", asq_pkg::OFF_STAT, 32'h0000_0114);
    for (k = 0; k < 4; k++)
    begin
      rchk("queue pop", asq_pkg::OFF_QUEUE, {19'h0, 3'(k + 1), 10'h3F0 + 10'(k)});
      rchk("count", asq_pkg::OFF_STAT, {22'h0, 4'h4, k == 3, 2'h0, 3'(3 - k)});
    end
    apb(1'b1, asq_pkg::OFF_STAT, 32'h0000_01C0);
    apb(1'b0, asq_pkg::OFF_QUEUE, 32'h0);
    rchk("underflow", asq_pkg::OFF_STAT, 32'h0000_00A0);
    $display("test queue done");

    apb(1'b1, asq_pkg::OFF_IRQC, 32'h0000_01C0);
    repeat (3) @(posedge pclk);
    chk("irq gated", 32'h0, {31'h0, irq});
    for (k = 6; k < 9; k++)
    begin
      apb(1'b1, asq_pkg::OFF_IRQC, 32'h200 | (32'h1 << k));
      repeat (3) @(posedge pclk);
      chk("irq enable", {31'h0, k == 7}, {31'h0, irq});
    end
    apb(1'b1, asq_pkg::OFF_IRQC, 32'h0000_0280);
    rchk("irq status", asq_pkg::OFF_STAT, 32'h0000_02A0);
    apb(1'b1, asq_pkg::OFF_CLR, 32'h0000_0080);
    repeat (3) @(posedge pclk);
    chk("irq cleared", 32'h0, {31'h0, irq});
    $display("test irq done");

    for (t = 0; t < 4; t++)
    begin
      soft_clear();
      apb(1'b1, asq_pkg::OFF_IRQC, 32'h8 | 32'(t));
      for (k = 1; k < 5; k++)
      begin
        send(3'h2, 10'(k));
        chk("dma", {31'h0, k > t}, {31'h0, dma_req});
        apb(1'b0, asq_pkg::OFF_STAT, 32'h0);
        chk("level", {31'h0, k > t}, {31'h0, rd[8]});
      end
    end
    $display("test threshold done");

    apb(1'b1, asq_pkg::OFF_CTRL, 32'h1);
    send(3'h4, 10'h155);
    rchk("soft reset", asq_pkg::OFF_STAT, 32'h0000_0020);
    chk("dma soft", 32'h0, {31'h0, dma_req});
    apb(1'b1, asq_pkg::OFF_CTRL, 32'h0);
    apb(1'b1, asq_pkg::OFF_IRQC, 32'hFFFF_FFFF);
    rchk("irqc layout", asq_pkg::OFF_IRQC, 32'h0000_03CF);
    apb(1'b0, 12'h018, 32'h0);
    chk("unmapped err", 32'h1, {31'h0, err});
    chk("unmapped data", 32'h0, rd);
    $display("test misc done");
    complete_run();
  end
endmodule // tb_top
